// [hdl/prot_seq_pkg.sv]
// constants and state type for the input protection sequencer
package prot_seq_pkg;
   localparam int unsigned CLK_FREQ_HZ        = 100_000_000;
   localparam int unsigned DEBOUNCE_TIME_MS   = 160;
   localparam int unsigned BLANK_TIME_MS      = 20;
   localparam int unsigned RETRY_TIME_MS      = 160;
   localparam int unsigned CYC_PER_MS         = CLK_FREQ_HZ / 1000;
   localparam int unsigned DEBOUNCE_CYCLES    = DEBOUNCE_TIME_MS * CYC_PER_MS;
   localparam int unsigned BLANK_CYCLES       = BLANK_TIME_MS * CYC_PER_MS;
   localparam int unsigned RETRY_CYCLES       = RETRY_TIME_MS * CYC_PER_MS;
   localparam int unsigned TIMER_W            = 25;

   typedef enum logic [2:0]
   {
      ST_OFF,
      ST_DEBOUNCE,
      ST_ON,
      ST_BLANK,
      ST_RETRY,
      ST_THERMAL
   } seq_state_t;
endpackage : prot_seq_pkg

// [hdl/input_protection_fault_sequencer.sv]
// control sequencer for a charger-input protection switch
//
// Summary of operation
// - input over/under voltage forces switch off
// - valid input waits 160ms before switch on
// - wait flag low during debounce and retry
// - wait flag released at switch on, never high
// - current at limit stays on 20ms
// - blank timer starts on current-limit onset
// - limit clears early: timer cleared, stay on
// - blank elapsed: switch off, start 160ms retry
// - retry end turns on; repeat while overcurrent
// - battery above 4.4V is a voltage fault
// - over temperature switches off at once
// - leave thermal shutdown after 10C cooling
// - enable input high keeps switch off
// - debounce runs only within voltage window
`timescale 1ns/1ps
module input_protection_fault_sequencer
#(
   parameter int unsigned DEBOUNCE_CYC = prot_seq_pkg::DEBOUNCE_CYCLES,
   parameter int unsigned BLANK_CYC    = prot_seq_pkg::BLANK_CYCLES,
   parameter int unsigned RETRY_CYC    = prot_seq_pkg::RETRY_CYCLES
)
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic resetn,
   // asynchronous fault indications and enable
   input  wire logic input_overvoltage_fault,
   input  wire logic input_undervoltage_fault,
   input  wire logic current_limit_active,
   input  wire logic battery_overvoltage_fault,
   input  wire logic thermal_trip_hot,
   input  wire logic thermal_cooled,
   input  wire logic enable_n,
   // switch control and open-drain wait flag
   output logic      pass_switch_on,
   output logic      startup_wait_flag_n_o,
   output logic      startup_wait_flag_n_oe_n
);
   import prot_seq_pkg::*;

   localparam int NSYNC = 7;

   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync2_reg;
   logic [NSYNC-1:0] raw_in;

   assign raw_in = {enable_n, thermal_cooled, thermal_trip_hot, battery_overvoltage_fault,
                    current_limit_active, input_undervoltage_fault, input_overvoltage_fault};

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         // both stages reset to disabled, so no false enable follows reset
         sync1_reg <= {1'b1, {(NSYNC-1){1'b0}}};
         sync2_reg <= {1'b1, {(NSYNC-1){1'b0}}};
      end
      else
      begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
      end
   end

   logic ov_s, uv_s, ilim_s, bat_s, hot_s, cool_s, en_n_s;
   assign ov_s   = sync2_reg[0];
   assign uv_s   = sync2_reg[1];
   assign ilim_s = sync2_reg[2];
   assign bat_s  = sync2_reg[3];
   assign hot_s  = sync2_reg[4];
   assign cool_s = sync2_reg[5];
   assign en_n_s = sync2_reg[6];

   logic volt_fault;
   logic any_fault;
   assign volt_fault = ov_s | uv_s | bat_s;
   assign any_fault  = volt_fault | en_n_s;

   seq_state_t           state_reg, state_next;
   logic [TIMER_W-1:0]   timer_reg, timer_next;
   logic                 switch_reg, switch_next;
   logic                 flag_oe_n_reg, flag_oe_n_next;

   always_comb
   begin
      state_next  = state_reg;
      timer_next  = timer_reg;
      if (hot_s)
      begin
         state_next = ST_THERMAL;
         timer_next = '0;
      end
      else if (any_fault && state_reg != ST_THERMAL)
      begin
         state_next = ST_OFF;
         timer_next = '0;
      end
      else
      begin
         unique case (state_reg)
            ST_OFF:
            begin
               state_next = ST_DEBOUNCE;
               timer_next = '0;
            end
            ST_DEBOUNCE:
            begin
               if (timer_reg == TIMER_W'(DEBOUNCE_CYC - 1))
               begin
                  state_next = ST_ON;
                  timer_next = '0;
               end
               else
                  timer_next = timer_reg + TIMER_W'(1);
            end
            ST_ON:
            begin
               timer_next = '0;
               if (ilim_s)
                  state_next = ST_BLANK;
            end
            ST_BLANK:
            begin
               if (!ilim_s)
               begin
                  state_next = ST_ON;
                  timer_next = '0;
               end
               else if (timer_reg == TIMER_W'(BLANK_CYC - 1))
               begin
                  state_next = ST_RETRY;
                  timer_next = '0;
               end
               else
                  timer_next = timer_reg + TIMER_W'(1);
            end
            ST_RETRY:
            begin
               if (timer_reg == TIMER_W'(RETRY_CYC - 1))
               begin
                  state_next = ST_ON;
                  timer_next = '0;
               end
               else
                  timer_next = timer_reg + TIMER_W'(1);
            end
            ST_THERMAL:
            begin
               timer_next = '0;
               if (cool_s)
                  state_next = ST_OFF;
            end
            default:
            begin
               state_next = ST_OFF;
               timer_next = '0;
            end
         endcase
      end
      switch_next    = (state_next == ST_ON) || (state_next == ST_BLANK);
      flag_oe_n_next = !((state_next == ST_DEBOUNCE) || (state_next == ST_RETRY));
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg     <= ST_OFF;
         timer_reg     <= '0;
         switch_reg    <= 1'b0;
         flag_oe_n_reg <= 1'b1;
      end
      else
      begin
         state_reg     <= state_next;
         timer_reg     <= timer_next;
         switch_reg    <= switch_next;
         flag_oe_n_reg <= flag_oe_n_next;
      end
   end

   assign pass_switch_on           = switch_reg;
   assign startup_wait_flag_n_oe_n = flag_oe_n_reg;
   assign startup_wait_flag_n_o    = 1'b0;

   // cycles the wait flag has been held low, checked against the intervals
   logic [TIMER_W-1:0]   wait_cnt_reg, wait_cnt_next;

   always_comb
   begin
      if (!startup_wait_flag_n_oe_n)
         wait_cnt_next = wait_cnt_reg + TIMER_W'(1);
      else
         wait_cnt_next = '0;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         wait_cnt_reg <= '0;
      else
         wait_cnt_reg <= wait_cnt_next;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_volt_off;
      volt_fault |=> !pass_switch_on;
   endproperty
   a_volt_off: assert property (p_volt_off) else $error("switch on during voltage fault");

   property p_enable_off;
      en_n_s |=> !pass_switch_on;
   endproperty
   a_enable_off: assert property (p_enable_off) else $error("switch on while disabled");

   property p_hot_off;
      hot_s |=> !pass_switch_on && state_reg == ST_THERMAL;
   endproperty
   a_hot_off: assert property (p_hot_off) else $error("switch on while hot");

   property p_thermal_exit;
      state_reg == ST_THERMAL && !cool_s && !hot_s |=> state_reg == ST_THERMAL;
   endproperty
   a_thermal_exit: assert property (p_thermal_exit) else $error("left thermal before cooling");

   property p_on_after_debounce;
      $rose(pass_switch_on) |-> $past(state_reg) == ST_DEBOUNCE || $past(state_reg) == ST_RETRY;
   endproperty
   a_on_after_debounce: assert property (p_on_after_debounce) else $error("switch on without wait");

   property p_debounce_len;
      $rose(pass_switch_on) && $past(state_reg) == ST_DEBOUNCE |-> wait_cnt_reg == TIMER_W'(DEBOUNCE_CYC);
   endproperty
   a_debounce_len: assert property (p_debounce_len) else $error("debounce length wrong");

   property p_flag_wait;
      (state_reg == ST_DEBOUNCE || state_reg == ST_RETRY) |-> !startup_wait_flag_n_oe_n && !pass_switch_on;
   endproperty
   a_flag_wait: assert property (p_flag_wait) else $error("wait flag not low");

   property p_flag_release;
      pass_switch_on |-> startup_wait_flag_n_oe_n;
   endproperty
   a_flag_release: assert property (p_flag_release) else $error("wait flag driven while on");

   sequence s_blank_start;
      state_reg == ST_ON && ilim_s && !any_fault && !hot_s;
   endsequence
   property p_blank_start;
      s_blank_start |=> state_reg == ST_BLANK && pass_switch_on && timer_reg == '0;
   endproperty
   a_blank_start: assert property (p_blank_start) else $error("blank did not start");

   property p_blank_clear;
      state_reg == ST_BLANK && !ilim_s && !any_fault && !hot_s |=> state_reg == ST_ON && pass_switch_on;
   endproperty
   a_blank_clear: assert property (p_blank_clear) else $error("blank not cleared");

   property p_blank_end;
      state_reg == ST_BLANK && ilim_s && !any_fault && !hot_s && timer_reg == TIMER_W'(BLANK_CYC - 1)
         |=> state_reg == ST_RETRY && !pass_switch_on && timer_reg == '0;
   endproperty
   a_blank_end: assert property (p_blank_end) else $error("retry not started");

   property p_debounce_abort;
      state_reg == ST_DEBOUNCE && any_fault && !hot_s |=> state_reg == ST_OFF ##1 timer_reg == '0;
   endproperty
   a_debounce_abort: assert property (p_debounce_abort) else $error("debounce not aborted");

   property p_retry_len;
      $rose(pass_switch_on) && $past(state_reg) == ST_RETRY |-> wait_cnt_reg == TIMER_W'(RETRY_CYC);
   endproperty
   a_retry_len: assert property (p_retry_len) else $error("retry length wrong");

   sequence s_retry_running;
      state_reg == ST_RETRY && !any_fault && !hot_s && timer_reg != TIMER_W'(RETRY_CYC - 1);
   endsequence
   property p_retry_hold;
      s_retry_running |=> state_reg == ST_RETRY && !pass_switch_on && !startup_wait_flag_n_oe_n;
   endproperty
   a_retry_hold: assert property (p_retry_hold) else $error("retry cut short");

   sequence s_debounce_running;
      state_reg == ST_DEBOUNCE && !any_fault && !hot_s && timer_reg != TIMER_W'(DEBOUNCE_CYC - 1);
   endsequence
   property p_debounce_hold;
      s_debounce_running |=> state_reg == ST_DEBOUNCE && !pass_switch_on && !startup_wait_flag_n_oe_n;
   endproperty
   a_debounce_hold: assert property (p_debounce_hold) else $error("debounce cut short");

   property p_blank_on;
      state_reg == ST_BLANK |-> pass_switch_on && startup_wait_flag_n_oe_n;
   endproperty
   a_blank_on: assert property (p_blank_on) else $error("switch off during blanking");

   property p_cooled_exit;
      state_reg == ST_THERMAL && cool_s && !hot_s |=> state_reg == ST_OFF && !pass_switch_on;
   endproperty
   a_cooled_exit: assert property (p_cooled_exit) else $error("thermal exit not taken");

endmodule : input_protection_fault_sequencer

// [verif/adapter_model.sv]
// adapter supply and charger side model for the protection sequencer
`timescale 1ns/1ps
module adapter_model
(
   // conditions commanded by the bench and the open-drain flag
   input  wire logic [6:0] cond,
   input  wire logic       flag_o,
   input  wire logic       flag_oe_n,
   // indications to the sequencer and flag pin with pull-up
   output logic [6:0]      ind,
   output logic            flag_pin
);
   // bit 6 is the controller enable, low for normal operation
   assign ind      = cond;
   assign flag_pin = flag_oe_n ? 1'b1 : flag_o;
endmodule : adapter_model

// [verif/input_protection_fault_sequencer_tb.sv]
// self-checking bench for the input protection sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module input_protection_fault_sequencer_tb;
   import prot_seq_pkg::*;
   localparam int DEB = 20;
   localparam int BLK = 5;
   localparam int RET = 20;
   logic       clk_sys;
   logic       resetn;
   logic       sw;
   logic       fo;
   logic       foe_n;
   logic       pin;
   logic [6:0] cond;
   logic [6:0] ind;
   int         fail_count = 0;
   int         n_tests = 0;
   int         c;

   input_protection_fault_sequencer #(.DEBOUNCE_CYC(DEB), .BLANK_CYC(BLK), .RETRY_CYC(RET)) i_dut
   (
      .clk_sys(clk_sys), .resetn(resetn),
      .input_overvoltage_fault(ind[0]), .input_undervoltage_fault(ind[1]),
      .current_limit_active(ind[2]), .battery_overvoltage_fault(ind[3]),
      .thermal_trip_hot(ind[4]), .thermal_cooled(ind[5]), .enable_n(ind[6]),
      .pass_switch_on(sw), .startup_wait_flag_n_o(fo), .startup_wait_flag_n_oe_n(foe_n)
   );
   adapter_model i_model (.cond(cond), .flag_o(fo), .flag_oe_n(foe_n), .ind(ind), .flag_pin(pin));

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic test_done;
      $display("tests %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   // bounded wait for a switch level, cycles returned in c
   task automatic wait_sw(input logic v, input int lim);
      c = 0;
      while (sw !== v && c < lim)
      begin
         tick(1);
         c++;
      end
      if (sw !== v)
      begin
         fail_count++;
         $display("FAIL switch wait exp %0h got %0h", v, sw);
         test_done();
      end
   endtask : wait_sw

   task automatic t_start;
      tick(5);
      `CHK("flag_debounce", 1'b0, pin)
      wait_sw(1'b1, DEB + 10);
      `CHK("debounce_len", DEB + 3, c + 5)
      `CHK("flag_release", 1'b1, pin)
   endtask : t_start

   // fault set, cleared, glitched mid-debounce, then full debounce again
   task automatic t_fault(input int b);
      cond[b] = 1'b1;
      wait_sw(1'b0, 4);
      `CHK("off_latency", 3, c)
      tick(6);
      `CHK("held_off", 1'b0, sw)
      cond[b] = 1'b0;
      tick(8);
      `CHK("flag_restart", 1'b0, pin)
      cond[b] = 1'b1;
      tick(4);
      cond[b] = 1'b0;
      wait_sw(1'b1, DEB + 10);
      `CHK("full_debounce", DEB + 3, c)
   endtask : t_fault

   task automatic t_blank_clear;
      repeat (2)
      begin
         cond[2] = 1'b1;
         tick(BLK - 1);
         cond[2] = 1'b0;
         repeat (8)
         begin
            tick(1);
            `CHK("blank_on", 1'b1, sw)
         end
      end
   endtask : t_blank_clear

   task automatic t_retry;
      cond[2] = 1'b1;
      wait_sw(1'b0, BLK + 8);
      `CHK("blank_len", BLK + 3, c)
      `CHK("flag_retry", 1'b0, pin)
      wait_sw(1'b1, RET + 8);
      `CHK("retry_len", RET, c)
      `CHK("flag_retry_end", 1'b1, pin)
      wait_sw(1'b0, BLK + 8);
      `CHK("blank_again", BLK + 1, c)
      cond[2] = 1'b0;
      wait_sw(1'b1, RET + 8);
      `CHK("retry_again", RET, c)
      tick(3 * BLK);
      `CHK("stay_on", 1'b1, sw)
   endtask : t_retry

   task automatic t_thermal;
      cond[4] = 1'b1;
      wait_sw(1'b0, 4);
      `CHK("hot_latency", 3, c)
      cond[4] = 1'b0;
      tick(DEB + 10);
      `CHK("thermal_hold", 1'b0, sw)
      cond[5] = 1'b1;
      wait_sw(1'b1, 2 * DEB);
      `CHK("thermal_restart", DEB + 4, c)
   endtask : t_thermal

   // mid-run reset while disabled, then enabled again
   task automatic t_reset;
      cond[6] = 1'b1;
      resetn  = 1'b0;
      #1;
      `CHK("reset_off", 1'b0, sw)
      `CHK("reset_flag", 1'b1, pin)
      tick(2);
      resetn = 1'b1;
      repeat (6)
      begin
         tick(1);
         `CHK("disabled_flag", 1'b1, pin)
      end
      cond[6] = 1'b0;
      wait_sw(1'b1, DEB + 10);
      `CHK("reset_debounce", DEB + 3, c)
   endtask : t_reset

   initial
   begin
      resetn = 1'b0;
      cond   = 7'h00;
      tick(2);
      resetn = 1'b1;
      t_start();
      t_fault(0);
      t_fault(1);
      t_fault(3);
      t_fault(6);
      t_blank_clear();
      t_retry();
      t_thermal();
      t_reset();
      test_done();
   end
endmodule : input_protection_fault_sequencer_tb
